// >>> design/wpsd_top.sv
// Wake pin direction, data and SMI routing with an AHB-Lite register slave
//
// Functional notes
// [RULE1] Pin 2 has an SMI enable bit that resets to 0 and gates its SMI.
// [RULE2] A pin 2 transition counts only after the new level holds for 31 us.
// [RULE3] Software keeps pin 2 an input when it wants an SMI from it.
// [RULE4] With pin 2 SMI enabled its events become SMI, not SCI, and flag SMI status bit 0; the code flags status bit 2 for every pin 2 input event.
// [RULE5] Pin 1 has an SMI enable bit that resets to 0 and gates its SMI.
// [RULE6] Software makes pin 1 an input before relying on its SMI.
// [RULE7] With pin 1 SMI enabled its events become SMI, overriding its SCI enable.
// [RULE8] Pin 0 has an SMI enable bit that resets to 0 and gates its SMI.
// [RULE9] Software makes pin 0 an input so that it can raise an SMI.
// [RULE10] With pin 0 SMI enabled its events become SMI instead of following its SCI enable.
// [RULE11] Pins 1 and 0 use the debounce chosen by the debounce select bit.
// [RULE12] Each pin has a direction bit, 0 input and 1 output.
// [RULE13] Data writes land only on output pins, which read back the last written value.
// [RULE14] Enabled events of all three pins merge into one SMI request.
`timescale 1ns/10ps
`include "wpsd_params.svh"
module wpsd_top #(
  parameter int DEB_ALT_CYCLES = `WPSD_DEB2_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [2:0]  wake_pin_i,
  output logic [2:0]       wake_pin_o,
  output logic [2:0]       wake_pin_oe,
  output logic             smi_event,
  output logic [2:0]       sci_event,
  output logic             irq
);
  import wpsd_pkg::*;

  localparam int         CW        = 12;
  localparam logic [CW-1:0] DEB2_LIM = CW'(`WPSD_DEB2_CYCLES);
  localparam logic [CW-1:0] ALT_LIM  = CW'(DEB_ALT_CYCLES);

  // ==========================================================================
  // State
  wpsd_ctrl_t   ctrl_q;
  logic [2:0]   data_q;
  logic [3:0]   cfg_q;
  logic [2:0]   stat_q;
  logic [2:0]   ien_q;
  wpsd_aphase_t ap_q;
  logic         rd_wait_q;
  logic         upper_ok_q;
  logic [2:0]   wake_sync;
  logic [2:0]   deb_level;
  logic [2:0]   deb_edge;

  function automatic logic hit(input wpsd_aphase_t ap, input logic [7:0] off);
    hit = ap.wr && (ap.addr == off);
  endfunction : hit

  // ==========================================================================
  // AHB-Lite address phase decode
  wire          take_ap  = hsel && htrans[1] && hready && hreadyout;
  wire          word_ok  = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
  wpsd_aphase_t ap_d;
  assign ap_d.wr   = take_ap && hwrite && word_ok;
  assign ap_d.rd   = take_ap && !hwrite;
  assign ap_d.addr = haddr[7:0];

  wire wr_ctrl  = hit(ap_q, `WPSD_OFF_CTRL2);
  wire wr_data  = hit(ap_q, `WPSD_OFF_DATA);
  wire wr_cfg   = hit(ap_q, `WPSD_OFF_CFG);
  wire wr_clear = hit(ap_q, `WPSD_OFF_CLEAR);
  wire wr_ien   = hit(ap_q, `WPSD_OFF_ENABLE);
  wire upper_ok = (haddr[31:8] == 24'h000000);

  // ==========================================================================
  // Register next values
  wpsd_ctrl_t ctrl_d;
  assign ctrl_d = wr_ctrl ? wpsd_ctrl_t'({1'b0, hwdata[6:4], 1'b0, hwdata[2:0]}) : ctrl_q;

  // Input pins keep their stored bit; only output bits take the write
  wire [2:0] data_d = wr_data ? ((data_q & ~ctrl_q.dir) | (hwdata[2:0] & ctrl_q.dir)) : data_q; // see [RULE13]
  wire [3:0] cfg_d  = wr_cfg ? hwdata[3:0] : cfg_q;
  wire [2:0] ien_d  = wr_ien ? hwdata[2:0] : ien_q;

  // ==========================================================================
  // Pin path
  wpsd_sync #(
    .W (3)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (wake_pin_i),
    .q     (wake_sync)
  );

  wire debsel = cfg_q[`WPSD_CFG_DEBSEL_BIT];

  // Pin 2 is fixed; pins 1 and 0 follow the select, sync-only when clear
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
      wpsd_dbnc #(
        .CW (CW)
      ) u_dbnc (
        .clk     (hclk),
        .rst_n   (hresetn),
        .sig     (wake_sync[gi]),
        .bypass  ((gi == 2) ? 1'b0 : !debsel),   // see [RULE11]
        .limit   ((gi == 2) ? DEB2_LIM : ALT_LIM), // see [RULE2]
        .level_q (deb_level[gi]),
        .edge_q  (deb_edge[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Event routing
  // Outputs never raise events: a driven pin would only see its own drive
  wire [2:0] pin_ev  = deb_edge & ~ctrl_q.dir;                       // see [RULE3] see [RULE6] see [RULE9] see [RULE12]
  wire [2:0] smi_vec = pin_ev & ctrl_q.smi_en;                       // see [RULE1] see [RULE5] see [RULE8]
  wire [2:0] sci_vec = pin_ev & ~ctrl_q.smi_en & cfg_q[2:0];         // see [RULE4] see [RULE7] see [RULE10]
  wire       smi_any = |smi_vec;                                     // see [RULE14]

  // Set beats clear in the same cycle
  wire [2:0] stat_d  = (stat_q & ~(wr_clear ? hwdata[2:0] : 3'h0)) | pin_ev;
  wire       irq_d   = |(stat_d & ien_d);

  // ==========================================================================
  // Read mux
  wire [2:0]  pin_view = (data_q & ctrl_q.dir) | (deb_level & ~ctrl_q.dir); // see [RULE13]
  wire [31:0] rd_mux   =
    (ap_q.addr == `WPSD_OFF_CTRL2)  ? {24'h000000, ctrl_q}           :
    (ap_q.addr == `WPSD_OFF_DATA)   ? {29'h00000000, pin_view}       :
    (ap_q.addr == `WPSD_OFF_CFG)    ? {28'h0000000, cfg_q}           :
    (ap_q.addr == `WPSD_OFF_STATUS) ? {29'h00000000, stat_q}         :
    (ap_q.addr == `WPSD_OFF_ENABLE) ? {29'h00000000, ien_q}          :
                                      32'h00000000;

  // ==========================================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= wpsd_ctrl_t'(`WPSD_RST_CTRL2);   // see [RULE1] see [RULE5] see [RULE8]
      data_q <= `WPSD_RST_DATA;
      cfg_q  <= `WPSD_RST_CFG;
      stat_q <= `WPSD_RST_IRQ;
      ien_q  <= `WPSD_RST_IRQ;
    end else begin
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      cfg_q  <= cfg_d;
      stat_q <= stat_d;
      ien_q  <= ien_d;
    end
  end

  // Reads insert one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q      <= '0;
      rd_wait_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
    end else begin
      ap_q      <= rd_wait_q ? '0 : wpsd_aphase_t'({ap_d.wr && upper_ok, ap_d.rd, ap_d.addr});
      rd_wait_q <= ap_d.rd;
      hreadyout <= !ap_d.rd;
      hrdata    <= rd_wait_q ? (upper_ok_q ? rd_mux : 32'h00000000) : hrdata;
    end
  end

  // Upper address check is kept for the data phase of a read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_ok_q <= 1'b0;
    end else begin
      upper_ok_q <= upper_ok;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_pin_o  <= 3'h0;
      wake_pin_oe <= 3'h0;
      smi_event   <= 1'b0;
      sci_event   <= 3'h0;
      irq         <= 1'b0;
    end else begin
      wake_pin_o  <= data_d;
      wake_pin_oe <= ctrl_d.dir;   // see [RULE12]
      smi_event   <= smi_any;      // see [RULE4] see [RULE14]
      sci_event   <= sci_vec;
      irq         <= irq_d;
    end
  end

  assign hresp = 1'b0;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_taken;
    ap_d.rd;
  endsequence
  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence

  rd_wait_a: assert property (s_read_taken |=> s_read_done) // see [RULE13]
    else $error("read did not complete after one wait state");
  smi_route_a: assert property (|(pin_ev & ctrl_q.smi_en) |=> smi_event) // see [RULE14]
    else $error("enabled pin event did not raise SMI");
  smi_gate_a: assert property (!(|(deb_edge & ~ctrl_q.dir & ctrl_q.smi_en)) |=> !smi_event) // see [RULE1]
    else $error("SMI without an enabled input event");
  sci_override_a: assert property (|(deb_edge & ctrl_q.smi_en) |=> !(|(sci_event & $past(ctrl_q.smi_en)))) // see [RULE4]
    else $error("SCI raised although SMI enable overrides it");
  out_noevent_a: assert property (deb_edge[0] && ctrl_q.dir[0] |=> !sci_event[0]) // see [RULE9]
    else $error("output pin produced an event");
  dir_oe_a: assert property (wr_ctrl |=> wake_pin_oe == $past(hwdata[2:0])) // see [RULE12]
    else $error("direction write not reflected on output enables");
  data_in_a: assert property (wr_data && !ctrl_q.dir[1] |=> data_q[1] == $past(data_q[1])) // see [RULE13]
    else $error("write landed on an input pin");
  stat_set_a: assert property (pin_ev[2] |=> stat_q[2] ##1 irq == (ien_q[2] || $past(irq))) // see [RULE4]
    else $error("pin event not latched in status");
  irq_level_a: assert property (##1 irq == $past(|(stat_d & ien_d)))
    else $error("interrupt output does not follow status and enable");
  deb_sel_a: assert property (!debsel && !ctrl_q.dir[0] && $rose(wake_sync[0]) && !deb_level[0]
    |=> deb_edge[0]) // see [RULE11]
    else $error("pin 0 not taken at once with debounce bypassed");

  // ==========================================================================
  // Bus and register checks
  sequence s_write_taken;
    ap_d.wr;
  endsequence
  sequence s_read_data;
    rd_wait_q;
  endsequence

  hresp_okay_a: assert property (
    hresp == 1'b0)
    else $error("slave response was not OKAY");
  wr_nowait_a: assert property (
    s_write_taken |=> hreadyout)
    else $error("write inserted a wait state");
  rd_data_a: assert property ( // see [RULE13]
    s_read_data |=> hrdata == $past(upper_ok_q ? rd_mux : 32'h00000000))
    else $error("read data not loaded in the wait state");
  oe_dir_a: assert property ( // see [RULE12]
    wake_pin_oe == ctrl_q.dir)
    else $error("output enables differ from direction bits");
  pin_out_a: assert property ( // see [RULE13]
    wake_pin_o == data_q)
    else $error("pin drive differs from stored data");

  // ==========================================================================
  // Event and status checks
  sequence s_pin2_smi;
    deb_edge[2] && !ctrl_q.dir[2] && ctrl_q.smi_en[2];
  endsequence
  sequence s_pin2_out;
    smi_event && !sci_event[2];
  endsequence

  pin2_smi_a: assert property ( // see [RULE4]
    s_pin2_smi |=> s_pin2_out)
    else $error("pin 2 event not routed to SMI");
  smi_cause_a: assert property ( // see [RULE5]
    smi_event |-> $past(|(pin_ev & ctrl_q.smi_en)))
    else $error("SMI without an enabled pin event");
  sci_cause_a: assert property ( // see [RULE7]
    sci_event[1] |-> $past(cfg_q[1]) && !$past(ctrl_q.smi_en[1]))
    else $error("pin 1 SCI without its enable or despite SMI enable");
  set_wins_a: assert property (
    pin_ev[0] |=> stat_q[0])
    else $error("status bit lost against a clear");
  clear_a: assert property (
    wr_clear && !(|pin_ev) |=> (stat_q & $past(hwdata[2:0])) == 3'h0)
    else $error("status clear did not take effect");

endmodule : wpsd_top

// >>> design/wpsd_params.svh
// Register map, reset values, field positions and timing counts of the wake pin block
`ifndef WPSD_PARAMS_SVH
`define WPSD_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define WPSD_OFF_CTRL2    8'h00
`define WPSD_OFF_DATA     8'h04
`define WPSD_OFF_CFG      8'h08
`define WPSD_OFF_STATUS   8'h0C
`define WPSD_OFF_CLEAR    8'h10
`define WPSD_OFF_ENABLE   8'h14

// ==========================================================================
// Reset values
`define WPSD_RST_CTRL2    8'h00
`define WPSD_RST_DATA     3'h0
`define WPSD_RST_CFG      4'h0
`define WPSD_RST_IRQ      3'h0

// ==========================================================================
// Field positions
`define WPSD_CTRL2_DIR_LSB  0
`define WPSD_CTRL2_SMI_LSB  4
`define WPSD_CFG_SCI_LSB    0
`define WPSD_CFG_DEBSEL_BIT 3

// ==========================================================================
// Timing
`define WPSD_CLK_PERIOD_NS  8
`define WPSD_DEB2_TIME_NS   31000
`define WPSD_DEB2_CYCLES    ((`WPSD_DEB2_TIME_NS + `WPSD_CLK_PERIOD_NS - 1) / `WPSD_CLK_PERIOD_NS)

`endif

// >>> design/wpsd_pkg.sv
// Types shared by the wake pin block
package wpsd_pkg;

  // ==========================================================================
  // Control register two layout
  typedef struct packed {
    logic       rsvd7;
    logic [2:0] smi_en;
    logic       rsvd3;
    logic [2:0] dir;
  } wpsd_ctrl_t;

  // ==========================================================================
  // Captured AHB address phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } wpsd_aphase_t;

  // ==========================================================================
  // Events toward the SMI and SCI logic
  typedef struct packed {
    logic       smi;
    logic [2:0] sci;
  } wpsd_evt_t;

endpackage : wpsd_pkg

// >>> design/wpsd_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module wpsd_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : wpsd_sync

// >>> design/wpsd_dbnc.sv
// Debouncer: a new level is taken once it has held for limit cycles
`timescale 1ns/10ps
module wpsd_dbnc #(
  parameter int CW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          sig,
  input  wire logic          bypass,
  input  wire logic [CW-1:0] limit,
  output logic               level_q,
  output logic               edge_q
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire           differ = (sig != level_q);
  wire           take   = differ && (bypass || (cnt_q >= limit - CW'(1)));

  assign cnt_d = (!differ || take) ? '0 : cnt_q + CW'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= take ? sig : level_q;
      edge_q  <= take;
    end
  end

  // ==========================================================================
  // Checks
  dbnc_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE2]
    $changed(level_q) && !$past(bypass) |-> $past(cnt_q) >= $past(limit) - CW'(1))
    else $error("level changed before debounce interval");
  dbnc_glitch_a: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE2]
    !bypass && limit > CW'(2) && $past(sig) == $past(level_q) && sig != level_q ##1 sig == level_q
      |=> $stable(level_q))
    else $error("short glitch changed the level");
endmodule : wpsd_dbnc

// >>> testbench/testbench.sv
// Self-checking bench for the wake pin direction, data and SMI routing block
`timescale 1ns/10ps
`include "wpsd_params.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  import wpsd_pkg::*;
  // ==========================================================================
  // Signals
  // Small alternate debounce keeps the run short
  localparam int ALT  = 4;
  localparam int DEB2 = 3875;
  logic        hclk       = 1'b0;
  logic        hresetn    = 1'b0;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hwdata     = 32'h0;
  logic [2:0]  wake_pin_i = 3'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [2:0]  wake_pin_o;
  logic [2:0]  wake_pin_oe;
  logic        smi_event;
  logic [2:0]  sci_event;
  logic        irq;
  logic [31:0] rd;
  logic [3:0]  seen;
  int          n;
  int          fails   = 0;
  int          checked = 0;

  always #4 hclk = ~hclk;

  // One slave, so its hreadyout is the bus hready
  wpsd_top #(.DEB_ALT_CYCLES(ALT)) i_wpsd_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wake_pin_i(wake_pin_i),
    .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe), .smi_event(smi_event),
    .sci_event(sci_event), .irq(irq));

  // ==========================================================================
  // Bus and wait tasks
  task conclude;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 64) begin
        fails++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // Called at a rising edge; returns at the edge that ends the data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    hsize  <= sz;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 3'h2);
  endtask : wr

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 3'h2);
    `CHK(nm, exp, rd)
  endtask : rdchk

  // A negative result means nothing came out within max edges
  task wait_out(input int max);
    int k;
    n = -1;
    seen = 4'h0;
    for (k = 0; k < max; k++) begin
      @(posedge hclk);
      if ({smi_event, sci_event} !== 4'h0) begin
        n = k + 1;
        seen = {smi_event, sci_event};
        break;
      end
    end
  endtask : wait_out

  // ==========================================================================
  // Scenarios
  task t_reset;
    `CHK("irq", 1'b0, irq)
    `CHK("hresp", 1'b0, hresp)
    `CHK("oe", 3'h0, wake_pin_oe)
    rdchk("ctrl2", `WPSD_OFF_CTRL2, 32'h0);
    rdchk("data", `WPSD_OFF_DATA, 32'h0);
    rdchk("cfg", `WPSD_OFF_CFG, 32'h0);
    rdchk("status", `WPSD_OFF_STATUS, 32'h0);
    rdchk("enable", `WPSD_OFF_ENABLE, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
  endtask : t_reset

  task t_dir;
    wr(`WPSD_OFF_CTRL2, 32'h5);
    wr(`WPSD_OFF_DATA, 32'h7);
    repeat (2) @(posedge hclk);
    `CHK("oe", 3'h5, wake_pin_oe)
    `CHK("pin out", 3'h5, wake_pin_o)
    rdchk("data back", `WPSD_OFF_DATA, 32'h5);
    // A byte write is dropped, so direction must stay
    bus(1'b1, `WPSD_OFF_CTRL2, 32'h0, 3'h0);
    rdchk("ctrl2 kept", `WPSD_OFF_CTRL2, 32'h5);
    wr(`WPSD_OFF_CTRL2, 32'h0);
  endtask : t_dir

  task t_route;
    wr(`WPSD_OFF_CTRL2, 32'h30);
    wr(`WPSD_OFF_CFG, 32'h7);
    wake_pin_i <= 3'h1;
    wait_out(20);
    `CHK("pin0 smi", 4'h8, seen)
    `CHK("pin0 fast", 1'b1, n <= 8)
    wake_pin_i <= 3'h3;
    wait_out(20);
    `CHK("pin1 smi", 4'h8, seen)
    wr(`WPSD_OFF_CTRL2, 32'h10);
    wake_pin_i <= 3'h1;
    wait_out(20);
    `CHK("pin1 sci", 4'h2, seen)
    wr(`WPSD_OFF_CTRL2, 32'h0);
    wake_pin_i <= 3'h0;
    wait_out(20);
    `CHK("pin0 sci", 4'h1, seen)
  endtask : t_route

  task t_pin2;
    wr(`WPSD_OFF_CTRL2, 32'h40);
    wake_pin_i <= 3'h4;
    repeat (1000) @(posedge hclk);
    wake_pin_i <= 3'h0;
    wait_out(DEB2 + 20);
    `CHK("pin2 glitch", -1, n)
    wake_pin_i <= 3'h4;
    wait_out(DEB2 + 20);
    `CHK("pin2 smi", 4'h8, seen)
    `CHK("pin2 delay", 1'b1, n >= DEB2 && n <= DEB2 + 8)
  endtask : t_pin2

  task t_alt;
    wr(`WPSD_OFF_CFG, 32'h8);
    wr(`WPSD_OFF_CTRL2, 32'h10);
    wake_pin_i <= 3'h5;
    repeat (2) @(posedge hclk);
    wake_pin_i <= 3'h4;
    wait_out(20);
    `CHK("alt glitch", -1, n)
    wake_pin_i <= 3'h5;
    wait_out(20);
    `CHK("alt delay", 1'b1, n >= ALT && n <= ALT + 8)
  endtask : t_alt

  task t_irq;
    rdchk("status all", `WPSD_OFF_STATUS, 32'h7);
    wr(`WPSD_OFF_ENABLE, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("irq on", 1'b1, irq)
    wr(`WPSD_OFF_CLEAR, 32'h1);
    rdchk("status cleared", `WPSD_OFF_STATUS, 32'h6);
    `CHK("irq off", 1'b0, irq)
    wr(`WPSD_OFF_ENABLE, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK("irq other", 1'b1, irq)
    wr(`WPSD_OFF_CLEAR, 32'h6);
    rdchk("status none", `WPSD_OFF_STATUS, 32'h0);
  endtask : t_irq

  task t_outdir;
    // Output pin with SMI enabled must stay silent
    wr(`WPSD_OFF_CTRL2, 32'h11);
    wake_pin_i <= 3'h4;
    wait_out(30);
    `CHK("output quiet", -1, n)
  endtask : t_outdir

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_dir();
    t_route();
    t_pin2();
    t_alt();
    t_irq();
    t_outdir();
    conclude();
  end
endmodule : testbench
